// file: shared/dacr_cfg.svh
`ifndef DACR_CFG_SVH
`define DACR_CFG_SVH

// Core clock period and documented conversion times, in their own units.
`define DACR_CLK_PERIOD_NS 25
`define DACR_CONV_TIME_NS 570
`define DACR_OS128_TIME_NS 112000
`define DACR_OS_MAX_RATIO 128
`define DACR_BUSY_DLY_NS 32

// Cycle counts derived from the times; all round down, and only the busy delay is held at no less than one cycle.
`define DACR_CONV_CYC (`DACR_CONV_TIME_NS / `DACR_CLK_PERIOD_NS)
`define DACR_PASS_CYC (`DACR_OS128_TIME_NS / `DACR_OS_MAX_RATIO / `DACR_CLK_PERIOD_NS)
`define DACR_BUSY_DLY_RAW (`DACR_BUSY_DLY_NS / `DACR_CLK_PERIOD_NS)
`define DACR_BUSY_DLY_CYC ((`DACR_BUSY_DLY_RAW < 1) ? 1 : `DACR_BUSY_DLY_RAW)

// Widths and depths.
`define DACR_RES_W 16
`define DACR_CH_W 4
`define DACR_OSR_W 3
`define DACR_SEQ_DEPTH 8
`define DACR_SEQ_IDX_W 3
`define DACR_CNT_W 6
`define DACR_ACC_W 23

// Range select pattern that selects software mode.
`define DACR_RANGE_SW 2'h0

// Channel codes: 0 to 7 are the analog inputs, then the two diagnostic channels.
`define DACR_CH_DIAG_AVDD 4'h8
`define DACR_CH_DIAG_LDO 4'h9

// Reset values.
`define DACR_RST_DATA 16'h0000
`define DACR_RST_CH 4'h0

`endif

// file: shared/dacr_pkg.sv
`include "dacr_cfg.svh"

package dacr_pkg;

   // Conversion control states, one-hot.
   typedef enum logic [3:0] {
      DACR_ST_IDLE = 4'h1,
      DACR_ST_DELAY = 4'h2,
      DACR_ST_CONV = 4'h4,
      DACR_ST_DONE = 4'h8
   } dacr_state_t;

   // Whole state of the control and readout module.
   typedef struct packed {
      dacr_state_t state;
      logic busy;
      logic mode_sw;
      logic [1:0] range;
      logic conv_sw;
      logic [`DACR_OSR_W-1:0] osr;
      logic [`DACR_CH_W-1:0] ch_a;
      logic [`DACR_CH_W-1:0] ch_b;
      logic [`DACR_SEQ_IDX_W-1:0] seq_idx;
      logic [`DACR_SEQ_DEPTH-1:0][2*`DACR_CH_W-1:0] seq_tab;
      logic [`DACR_CNT_W-1:0] cnt;
      logic [7:0] pass;
      logic [`DACR_ACC_W-1:0] acc_a;
      logic [`DACR_ACC_W-1:0] acc_b;
      logic [`DACR_RES_W-1:0] res_a;
      logic [`DACR_RES_W-1:0] res_b;
      logic rd_ptr;
      logic [`DACR_RES_W-1:0] par_data;
      logic par_oe_n;
      logic [`DACR_RES_W-1:0] sh_a;
      logic [`DACR_RES_W-1:0] sh_b;
      logic sdo_a;
      logic sdo_b;
      logic sdo_oe_n;
   } dacr_core_t;

   // State of the pin synchroniser: two stages plus one edge history stage.
   typedef struct packed {
      logic [11:0] s1;
      logic [11:0] s2;
      logic [11:0] s3;
   } dacr_sync_t;

endpackage : dacr_pkg

// file: shared/dacr_pin_if.sv
`timescale 1ns/1ps
`include "dacr_cfg.svh"

// Synchronised pin levels and edge pulses passed from the synchroniser to the core.
interface dacr_pin_if;
   logic [1:0] range_select;
   logic [2:0] channel_select;
   logic [`DACR_OSR_W-1:0] osr_select;
   logic cs_n;
   logic conversion_start_rise;
   logic cs_fall;
   logic cs_rise;
   logic rd_fall;
   logic sclk_rise;

   modport src (
      output range_select,
      output channel_select,
      output osr_select,
      output cs_n,
      output conversion_start_rise,
      output cs_fall,
      output cs_rise,
      output rd_fall,
      output sclk_rise
   );

   modport dst (
      input range_select,
      input channel_select,
      input osr_select,
      input cs_n,
      input conversion_start_rise,
      input cs_fall,
      input cs_rise,
      input rd_fall,
      input sclk_rise
   );
endinterface : dacr_pin_if

// file: hw/dacr_pin_sync.sv
`timescale 1ns/1ps
`include "dacr_cfg.svh"

module dacr_pin_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [1:0] range_select_pins,
   input wire logic [2:0] channel_select_pins,
   input wire logic [`DACR_OSR_W-1:0] osr_select_pins,
   input wire logic conversion_start,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic serial_clock,
   dacr_pin_if.src pins
);

   // Bit order: range, channel, osr, conversion_start, cs_n, rd_n, sclk.
   localparam int SCLK_B = 0;
   localparam int RD_B = 1;
   localparam int CS_B = 2;
   localparam int CNV_B = 3;

   dacr_pkg::dacr_sync_t st_r;
   dacr_pkg::dacr_sync_t st_nxt;
   logic [11:0] raw;

   // Gather every asynchronous pin into one vector.
   assign raw = {range_select_pins, channel_select_pins, osr_select_pins,
                 conversion_start, chip_select_n, read_strobe_n, serial_clock};

   // Shift pins through two sync stages; the third stage only keeps edge history.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = raw;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   // Idle levels: read strobe and chip select high, everything else low.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '{s1: 12'h006, s2: 12'h006, s3: 12'h006};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Levels and edges are taken only from the second and third stages.
   assign pins.range_select = st_r.s2[11:10];
   assign pins.channel_select = st_r.s2[9:7];
   assign pins.osr_select = st_r.s2[6:4];
   assign pins.cs_n = st_r.s2[CS_B];
   assign pins.conversion_start_rise = st_r.s2[CNV_B] & ~st_r.s3[CNV_B];
   assign pins.cs_fall = ~st_r.s2[CS_B] & st_r.s3[CS_B];
   assign pins.cs_rise = st_r.s2[CS_B] & ~st_r.s3[CS_B];
   assign pins.rd_fall = ~st_r.s2[RD_B] & st_r.s3[RD_B];
   assign pins.sclk_rise = st_r.s2[SCLK_B] & ~st_r.s3[SCLK_B];

endmodule : dacr_pin_sync

// file: hw/dacr_top.sv
`timescale 1ns/1ps
`include "dacr_cfg.svh"

module dacr_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [1:0] range_select_pins,
   input wire logic [2:0] channel_select_pins,
   input wire logic [`DACR_OSR_W-1:0] osr_select_pins,
   input wire logic conversion_start,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic serial_clock,
   input wire logic [`DACR_CH_W-1:0] sw_channel_a,
   input wire logic [`DACR_CH_W-1:0] sw_channel_b,
   input wire logic [`DACR_OSR_W-1:0] sw_osr_select,
   input wire logic seq_enable,
   input wire logic [`DACR_SEQ_IDX_W-1:0] seq_last,
   input wire logic seq_wr_en,
   input wire logic [`DACR_SEQ_IDX_W-1:0] seq_wr_idx,
   input wire logic [`DACR_CH_W-1:0] seq_wr_channel_a,
   input wire logic [`DACR_CH_W-1:0] seq_wr_channel_b,
   input wire logic [`DACR_RES_W-1:0] adc_a_data,
   input wire logic [`DACR_RES_W-1:0] adc_b_data,
   output logic busy,
   output logic sw_mode,
   output logic [1:0] hw_range_code,
   output logic [`DACR_CH_W-1:0] mux_a_select,
   output logic [`DACR_CH_W-1:0] mux_b_select,
   output logic [`DACR_RES_W-1:0] parallel_data_bus_out,
   output logic parallel_data_bus_oe_n,
   output logic serial_out_lane_a_out,
   output logic serial_out_lane_b_out,
   output logic serial_out_lanes_oe_n
);

   localparam int CONV_MAX = `DACR_CONV_CYC;
   localparam int PASS_LAST = `DACR_PASS_CYC - 1;
   localparam logic [`DACR_CNT_W-1:0] CONV_LOAD = `DACR_CNT_W'(`DACR_CONV_CYC - 1);
   localparam logic [`DACR_CNT_W-1:0] PASS_LOAD = `DACR_CNT_W'(`DACR_PASS_CYC - 1);
   localparam logic [`DACR_CNT_W-1:0] BUSY_LOAD = `DACR_CNT_W'(`DACR_BUSY_DLY_CYC - 1);

   dacr_pin_if pins ();
   dacr_pkg::dacr_core_t st_r;
   dacr_pkg::dacr_core_t st_nxt;
   logic [`DACR_RES_W-1:0] rd_word;

   // Sign-extends one converter sample to accumulator width.
   function automatic logic [`DACR_ACC_W-1:0] sext(input logic [`DACR_RES_W-1:0] d);
      sext = {{(`DACR_ACC_W-`DACR_RES_W){d[`DACR_RES_W-1]}}, d};
   endfunction : sext

   // Averages an accumulated sum by the power-of-two ratio.
   function automatic logic [`DACR_RES_W-1:0] avg(input logic [`DACR_ACC_W-1:0] sum,
                                                  input logic [`DACR_OSR_W-1:0] osr);
      logic signed [`DACR_ACC_W-1:0] s;
      s = $signed(sum) >>> osr;
      avg = s[`DACR_RES_W-1:0];
   endfunction : avg

   dacr_pin_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .range_select_pins(range_select_pins),
      .channel_select_pins(channel_select_pins),
      .osr_select_pins(osr_select_pins),
      .conversion_start(conversion_start),
      .chip_select_n(chip_select_n),
      .read_strobe_n(read_strobe_n),
      .serial_clock(serial_clock),
      .pins(pins)
   );

   // Word that the next read strobe places on the bus: bank A result first, then bank B.
   assign rd_word = st_r.rd_ptr ? st_r.res_b : st_r.res_a;

   // Next-state logic for mode, channel choice, conversion timing, averaging and readout.
   always_comb begin
      logic [`DACR_ACC_W-1:0] sum_a;
      logic [`DACR_ACC_W-1:0] sum_b;
      logic [2*`DACR_CH_W-1:0] seq_ent;
      sum_a = st_r.acc_a + sext(adc_a_data);
      sum_b = st_r.acc_b + sext(adc_b_data);
      seq_ent = st_r.seq_tab[st_r.seq_idx];
      st_nxt = st_r;
      st_nxt.mode_sw = (pins.range_select == `DACR_RANGE_SW);
      st_nxt.range = pins.range_select;
      if (seq_wr_en) begin
         st_nxt.seq_tab[seq_wr_idx] = {seq_wr_channel_a, seq_wr_channel_b};
      end
      if (!seq_enable) begin
         st_nxt.seq_idx = '0;
      end
      case (st_r.state)
         dacr_pkg::DACR_ST_IDLE: begin
            if (pins.conversion_start_rise) begin
               st_nxt.conv_sw = st_r.mode_sw;
               if (st_r.mode_sw) begin
                  st_nxt.osr = sw_osr_select;
                  if (seq_enable) begin
                     st_nxt.ch_a = seq_ent[2*`DACR_CH_W-1:`DACR_CH_W];
                     st_nxt.ch_b = seq_ent[`DACR_CH_W-1:0];
                     st_nxt.seq_idx = (st_r.seq_idx == seq_last) ? '0 : st_r.seq_idx + 1'b1;
                  end else begin
                     st_nxt.ch_a = sw_channel_a;
                     st_nxt.ch_b = sw_channel_b;
                  end
               end else begin
                  st_nxt.osr = pins.osr_select;
                  st_nxt.ch_a = {1'b0, pins.channel_select};
                  st_nxt.ch_b = {1'b0, pins.channel_select};
               end
               st_nxt.cnt = BUSY_LOAD;
               st_nxt.state = dacr_pkg::DACR_ST_DELAY;
            end
         end
         dacr_pkg::DACR_ST_DELAY: begin
            if (st_r.cnt == '0) begin
               st_nxt.busy = 1'b1;
               st_nxt.pass = '0;
               st_nxt.acc_a = '0;
               st_nxt.acc_b = '0;
               st_nxt.cnt = (st_r.osr == '0) ? CONV_LOAD : PASS_LOAD;
               st_nxt.state = dacr_pkg::DACR_ST_CONV;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         dacr_pkg::DACR_ST_CONV: begin
            if (st_r.cnt != '0) begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end else if (st_r.pass == 8'((1 << st_r.osr) - 1)) begin
               st_nxt.res_a = avg(sum_a, st_r.osr);
               st_nxt.res_b = avg(sum_b, st_r.osr);
               st_nxt.busy = 1'b0;
               st_nxt.state = dacr_pkg::DACR_ST_DONE;
            end else begin
               st_nxt.acc_a = sum_a;
               st_nxt.acc_b = sum_b;
               st_nxt.pass = st_r.pass + 1'b1;
               st_nxt.cnt = PASS_LOAD;
            end
         end
         dacr_pkg::DACR_ST_DONE: begin
            st_nxt.state = dacr_pkg::DACR_ST_IDLE;
         end
         default: begin
            st_nxt.state = dacr_pkg::DACR_ST_IDLE;
            st_nxt.busy = 1'b0;
         end
      endcase
      // Readout: chip select fall rearms both paths; the serial lanes present the first bit at once.
      if (pins.cs_fall) begin
         st_nxt.rd_ptr = 1'b0;
         st_nxt.sh_a = st_r.res_a;
         st_nxt.sh_b = st_r.res_b;
         st_nxt.sdo_a = st_r.res_a[`DACR_RES_W-1];
         st_nxt.sdo_b = st_r.res_b[`DACR_RES_W-1];
         st_nxt.sdo_oe_n = 1'b0;
      end else if (!pins.cs_n) begin
         if (pins.rd_fall) begin
            st_nxt.par_data = rd_word;
            st_nxt.par_oe_n = 1'b0;
            st_nxt.rd_ptr = ~st_r.rd_ptr;
         end
         if (pins.sclk_rise) begin
            st_nxt.sh_a = {st_r.sh_a[`DACR_RES_W-2:0], 1'b0};
            st_nxt.sh_b = {st_r.sh_b[`DACR_RES_W-2:0], 1'b0};
            st_nxt.sdo_a = st_r.sh_a[`DACR_RES_W-2];
            st_nxt.sdo_b = st_r.sh_b[`DACR_RES_W-2];
         end
      end else begin
         st_nxt.par_oe_n = 1'b1;
         st_nxt.sdo_oe_n = 1'b1;
      end
   end

   // Register the whole state.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '{state: dacr_pkg::DACR_ST_IDLE, busy: 1'b0, mode_sw: 1'b1, range: 2'h0,
                   conv_sw: 1'b1, osr: 3'h0, ch_a: `DACR_RST_CH, ch_b: `DACR_RST_CH,
                   seq_idx: 3'h0, seq_tab: '0, cnt: 6'h00, pass: 8'h00, acc_a: 23'h000000,
                   acc_b: 23'h000000, res_a: `DACR_RST_DATA, res_b: `DACR_RST_DATA,
                   rd_ptr: 1'b0, par_data: `DACR_RST_DATA, par_oe_n: 1'b1,
                   sh_a: `DACR_RST_DATA, sh_b: `DACR_RST_DATA, sdo_a: 1'b0, sdo_b: 1'b0,
                   sdo_oe_n: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state flops.
   assign busy = st_r.busy;
   assign sw_mode = st_r.mode_sw;
   assign hw_range_code = st_r.range;
   assign mux_a_select = st_r.ch_a;
   assign mux_b_select = st_r.ch_b;
   assign parallel_data_bus_out = st_r.par_data;
   assign parallel_data_bus_oe_n = st_r.par_oe_n;
   assign serial_out_lane_a_out = st_r.sdo_a;
   assign serial_out_lane_b_out = st_r.sdo_b;
   assign serial_out_lanes_oe_n = st_r.sdo_oe_n;

   // Start seen while idle, then busy two edges later.
   sequence s_start;
      pins.conversion_start_rise && (st_r.state == dacr_pkg::DACR_ST_IDLE);
   endsequence

   sequence s_busy_up;
      ##2 st_r.busy;
   endsequence

   property p_busy_rise;
      @(posedge core_clk) disable iff (rst) s_start |-> s_busy_up;
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise after start");

   property p_conv_len;
      @(posedge core_clk) disable iff (rst)
         ($rose(st_r.busy) && st_r.osr == '0) |-> ##[CONV_MAX:CONV_MAX] $fell(st_r.busy);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("plain conversion length wrong");

   property p_hw_pair;
      @(posedge core_clk) disable iff (rst)
         (st_r.busy && !st_r.conv_sw) |-> (mux_a_select == mux_b_select && !mux_a_select[3]);
   endproperty
   a_hw_pair: assert property (p_hw_pair) else $error("hardware pair or diag wrong");

   property p_hw_pins;
      @(posedge core_clk) disable iff (rst)
         (st_r.state == dacr_pkg::DACR_ST_DELAY && $changed(st_r.state) && !st_r.conv_sw)
            |-> st_r.ch_a[2:0] == $past(pins.channel_select);
   endproperty
   a_hw_pins: assert property (p_hw_pins) else $error("hardware channel not from pins");

   property p_sw_chan;
      @(posedge core_clk) disable iff (rst)
         (st_r.state == dacr_pkg::DACR_ST_DELAY && $changed(st_r.state) && st_r.conv_sw && !$past(seq_enable))
            |-> (st_r.ch_a == $past(sw_channel_a) && st_r.ch_b == $past(sw_channel_b));
   endproperty
   a_sw_chan: assert property (p_sw_chan) else $error("software channel not from settings");

   property p_rd_word;
      @(posedge core_clk) disable iff (rst)
         (pins.rd_fall && !pins.cs_n && !pins.cs_fall) |=> (parallel_data_bus_out == $past(rd_word)
            && !parallel_data_bus_oe_n);
   endproperty
   a_rd_word: assert property (p_rd_word) else $error("read word not placed");

   property p_db_release;
      @(posedge core_clk) disable iff (rst) pins.cs_rise |=> parallel_data_bus_oe_n;
   endproperty
   a_db_release: assert property (p_db_release) else $error("parallel bus not released");

   property p_sdo_hz;
      @(posedge core_clk) disable iff (rst) (pins.cs_n && $past(pins.cs_n)) |-> serial_out_lanes_oe_n;
   endproperty
   a_sdo_hz: assert property (p_sdo_hz) else $error("serial lanes driven while deselected");

   property p_sdo_shift;
      @(posedge core_clk) disable iff (rst)
         (pins.sclk_rise && !pins.cs_n && !pins.cs_fall) |=> (serial_out_lane_a_out == $past(st_r.sh_a[14])
            && serial_out_lane_b_out == $past(st_r.sh_b[14]));
   endproperty
   a_sdo_shift: assert property (p_sdo_shift) else $error("serial bit not launched");

   property p_mode;
      @(posedge core_clk) disable iff (rst) 1'b1 |=> sw_mode == ($past(pins.range_select) == 2'h0);
   endproperty
   a_mode: assert property (p_mode) else $error("mode does not follow range pins");

   // Sequencer, diagnostic, readout order, refusal and averaging pass checks.
   sequence s_seq_start;
      pins.conversion_start_rise && (st_r.state == dacr_pkg::DACR_ST_IDLE) && st_r.mode_sw && seq_enable;
   endsequence

   property p_diag_sw;
      @(posedge core_clk) disable iff (rst) (st_r.busy && (st_r.ch_a[3] || st_r.ch_b[3])) |-> st_r.conv_sw;
   endproperty
   a_diag_sw: assert property (p_diag_sw) else $error("diagnostic channel in hardware mode");

   property p_seq_step;
      @(posedge core_clk) disable iff (rst)
         s_seq_start |=> ({st_r.ch_a, st_r.ch_b} == $past(st_r.seq_tab[st_r.seq_idx]));
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("sequencer entry not applied");

   property p_seq_wrap;
      @(posedge core_clk) disable iff (rst)
         (s_seq_start ##0 (st_r.seq_idx == seq_last)) |=> (st_r.seq_idx == '0);
   endproperty
   a_seq_wrap: assert property (p_seq_wrap) else $error("sequencer did not wrap");

   property p_sdo_load;
      @(posedge core_clk) disable iff (rst)
         pins.cs_fall |=> (!serial_out_lanes_oe_n && serial_out_lane_a_out == $past(st_r.res_a[15])
            && serial_out_lane_b_out == $past(st_r.res_b[15]));
   endproperty
   a_sdo_load: assert property (p_sdo_load) else $error("serial lanes not loaded on select");

   property p_first_word;
      @(posedge core_clk) disable iff (rst)
         (pins.rd_fall && !pins.cs_n && !pins.cs_fall && !st_r.rd_ptr)
            |=> (parallel_data_bus_out == $past(st_r.res_a));
   endproperty
   a_first_word: assert property (p_first_word) else $error("first word is not bank A");

   property p_refuse;
      @(posedge core_clk) disable iff (rst)
         (pins.conversion_start_rise && st_r.state != dacr_pkg::DACR_ST_IDLE) |=> $stable({st_r.ch_a, st_r.ch_b, st_r.osr});
   endproperty
   a_refuse: assert property (p_refuse) else $error("start taken while converting");

   // One averaging pass: busy rises, then the cycle counter cnt reaches zero in the conversion state PASS_LAST cycles later.
   sequence s_os_start;
      $rose(st_r.busy) && (st_r.osr != '0);
   endsequence

   sequence s_pass_end;
      ##[PASS_LAST:PASS_LAST] ((st_r.cnt == '0) && (st_r.state == dacr_pkg::DACR_ST_CONV));
   endsequence

   property p_pass_len;
      @(posedge core_clk) disable iff (rst) s_os_start |-> s_pass_end;
   endproperty
   a_pass_len: assert property (p_pass_len) else $error("averaging pass length wrong");

endmodule : dacr_top

// file: sim/dacr_host_model.sv
`timescale 1ns/1ps

// Host controller side: drives start, select, read strobe and serial clock, and samples what comes back.
module dacr_host_model (
   input wire logic core_clk,
   input wire logic busy,
   input wire logic [15:0] data_bus,
   input wire logic lane_a,
   input wire logic lane_b,
   output logic conversion_start,
   output logic chip_select_n,
   output logic read_strobe_n,
   output logic serial_clock
);
   // Pins idle with the device deselected and the serial clock parked low between frames.
   initial begin
      conversion_start = 1'b0;
      chip_select_n = 1'b1;
      read_strobe_n = 1'b1;
      serial_clock = 1'b0;
   end

   // Starts a conversion with select high and measures busy; dbl repeats the start while busy to be refused.
   task automatic convert(input logic dbl, output int rise_dly, output int busy_len);
      rise_dly = 0;
      busy_len = 0;
      repeat (3) @(negedge core_clk);
      conversion_start = 1'b1;
      while (busy !== 1'b1 && rise_dly < 10) begin
         @(negedge core_clk);
         rise_dly++;
      end
      conversion_start = 1'b0;
      while (busy === 1'b1 && busy_len < 5000) begin
         @(negedge core_clk);
         busy_len++;
         conversion_start = dbl && busy_len >= 8 && busy_len < 12;
      end
   endtask : convert

   // Reads two words with slow strobes once busy is low, then samples the released bus.
   task automatic par_read(output logic [15:0] w0, output logic [15:0] w1, output logic [15:0] idle);
      chip_select_n = 1'b0;
      repeat (4) @(negedge core_clk);
      read_strobe_n = 1'b0;
      repeat (6) @(negedge core_clk);
      w0 = data_bus;
      read_strobe_n = 1'b1;
      repeat (4) @(negedge core_clk);
      read_strobe_n = 1'b0;
      repeat (6) @(negedge core_clk);
      w1 = data_bus;
      read_strobe_n = 1'b1;
      repeat (2) @(negedge core_clk);
      chip_select_n = 1'b1;
      repeat (5) @(negedge core_clk);
      idle = data_bus;
   endtask : par_read

   // Shifts sixteen bits from both lanes with a 200 ns serial clock stepped on core clock falling edges.
   task automatic ser_read(output logic [15:0] sa, output logic [15:0] sb, output logic [1:0] idle);
      chip_select_n = 1'b0;
      repeat (5) @(negedge core_clk);
      for (int k = 15; k >= 0; k--) begin
         sa[k] = lane_a;
         sb[k] = lane_b;
         serial_clock = 1'b1;
         repeat (4) @(negedge core_clk);
         serial_clock = 1'b0;
         repeat (4) @(negedge core_clk);
      end
      @(negedge core_clk);
      chip_select_n = 1'b1;
      repeat (5) @(negedge core_clk);
      idle = {lane_a, lane_b};
   endtask : ser_read
endmodule : dacr_host_model

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "dacr_cfg.svh"

module testbench;
   logic core_clk;
   logic rst;
   logic [1:0] range_select_pins;
   logic [2:0] channel_select_pins;
   logic [`DACR_OSR_W-1:0] osr_select_pins;
   logic conversion_start;
   logic chip_select_n;
   logic read_strobe_n;
   logic serial_clock;
   logic [`DACR_CH_W-1:0] sw_channel_a;
   logic [`DACR_CH_W-1:0] sw_channel_b;
   logic [`DACR_OSR_W-1:0] sw_osr_select;
   logic seq_enable;
   logic [`DACR_SEQ_IDX_W-1:0] seq_last;
   logic seq_wr_en;
   logic [`DACR_SEQ_IDX_W-1:0] seq_wr_idx;
   logic [`DACR_CH_W-1:0] seq_wr_channel_a;
   logic [`DACR_CH_W-1:0] seq_wr_channel_b;
   logic [`DACR_RES_W-1:0] adc_a_data;
   logic [`DACR_RES_W-1:0] adc_b_data;
   logic busy;
   logic sw_mode;
   logic [1:0] hw_range_code;
   logic [`DACR_CH_W-1:0] mux_a_select;
   logic [`DACR_CH_W-1:0] mux_b_select;
   logic [`DACR_RES_W-1:0] parallel_data_bus_out;
   logic parallel_data_bus_oe_n;
   logic serial_out_lane_a_out;
   logic serial_out_lane_b_out;
   logic serial_out_lanes_oe_n;
   int n_errors;
   int total_checks;
   int rise_dly;
   int busy_len;

   // Pin levels as the host sees them; they float while the device lets go.
   wire logic [`DACR_RES_W-1:0] data_bus = parallel_data_bus_oe_n ? 16'hzzzz : parallel_data_bus_out;
   wire logic lane_a = serial_out_lanes_oe_n ? 1'hz : serial_out_lane_a_out;
   wire logic lane_b = serial_out_lanes_oe_n ? 1'hz : serial_out_lane_b_out;

   dacr_top u_dut (.core_clk(core_clk), .rst(rst), .range_select_pins(range_select_pins),
      .channel_select_pins(channel_select_pins), .osr_select_pins(osr_select_pins),
      .conversion_start(conversion_start), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
      .serial_clock(serial_clock), .sw_channel_a(sw_channel_a), .sw_channel_b(sw_channel_b),
      .sw_osr_select(sw_osr_select), .seq_enable(seq_enable), .seq_last(seq_last), .seq_wr_en(seq_wr_en),
      .seq_wr_idx(seq_wr_idx), .seq_wr_channel_a(seq_wr_channel_a), .seq_wr_channel_b(seq_wr_channel_b),
      .adc_a_data(adc_a_data), .adc_b_data(adc_b_data), .busy(busy), .sw_mode(sw_mode),
      .hw_range_code(hw_range_code), .mux_a_select(mux_a_select), .mux_b_select(mux_b_select),
      .parallel_data_bus_out(parallel_data_bus_out), .parallel_data_bus_oe_n(parallel_data_bus_oe_n),
      .serial_out_lane_a_out(serial_out_lane_a_out), .serial_out_lane_b_out(serial_out_lane_b_out),
      .serial_out_lanes_oe_n(serial_out_lanes_oe_n));

   dacr_host_model u_host (.core_clk(core_clk), .busy(busy), .data_bus(data_bus), .lane_a(lane_a),
      .lane_b(lane_b), .conversion_start(conversion_start), .chip_select_n(chip_select_n),
      .read_strobe_n(read_strobe_n), .serial_clock(serial_clock));

   // Core clock at 40 MHz.
   always #12.5 core_clk = ~core_clk;

   // Counts a comparison and reports a difference at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Prints the verdict and stops the run.
   task automatic conclude();
      if (n_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   // One conversion with its expected busy width in core cycles.
   task automatic conv(input int exp_len, input logic dbl);
      u_host.convert(dbl, rise_dly, busy_len);
      chk(32'(rise_dly <= 5), 32'h1);
      chk(busy_len, exp_len);
      if (rise_dly >= 10 || busy_len >= 5000) begin
         conclude();
      end
   endtask : conv

   // Reads the pair back over the parallel bus and over both serial lanes.
   task automatic readback(input logic [15:0] ea, input logic [15:0] eb);
      logic [15:0] w0;
      logic [15:0] w1;
      logic [15:0] zb;
      logic [1:0] zl;
      u_host.par_read(w0, w1, zb);
      chk(w0, ea);
      chk(w1, eb);
      chk(zb, 16'hzzzz);
      u_host.ser_read(w0, w1, zl);
      chk(w0, ea);
      chk(w1, eb);
      chk(zl, 2'hz);
   endtask : readback

   // Main sequence: modes, hardware pairs, software pairs, every averaging ratio, then the sequencer.
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {range_select_pins, channel_select_pins, osr_select_pins} = 8'h00;
      {sw_channel_a, sw_channel_b, sw_osr_select} = 11'h000;
      {seq_enable, seq_last, seq_wr_en, seq_wr_idx} = 8'h00;
      {seq_wr_channel_a, seq_wr_channel_b} = 8'h00;
      adc_a_data = 16'h0000;
      adc_b_data = 16'h0000;
      n_errors = 0;
      total_checks = 0;
      repeat (20) @(negedge core_clk);
      chk({parallel_data_bus_oe_n, serial_out_lanes_oe_n}, 2'h3);
      rst = 1'b0;
      for (int p = 0; p < 4; p++) begin
         range_select_pins = 2'(p);
         repeat (5) @(negedge core_clk);
         chk(sw_mode, p == 0);
         chk(hw_range_code, p);
      end
      sw_channel_a = 4'h9;
      sw_channel_b = 4'h8;
      sw_osr_select = 3'h7;
      for (int k = 0; k < 8; k++) begin
         channel_select_pins = 3'(k);
         osr_select_pins = 3'(k == 7);
         adc_a_data = 16'h8000 | 16'(k);
         adc_b_data = 16'h7ff0 - 16'(k);
         conv(k == 7 ? 70 : 22, k == 7);
         chk(mux_a_select, k);
         chk(mux_b_select, k);
         readback(adc_a_data, adc_b_data);
      end
      range_select_pins = 2'h0;
      osr_select_pins = 3'h7;
      sw_osr_select = 3'h0;
      sw_channel_a = 4'h2;
      sw_channel_b = 4'h6;
      repeat (5) @(negedge core_clk);
      conv(22, 1'b0);
      chk({mux_a_select, mux_b_select}, 8'h26);
      sw_channel_a = 4'h8;
      sw_channel_b = 4'h9;
      conv(22, 1'b0);
      chk({mux_a_select, mux_b_select}, 8'h89);
      for (int o = 0; o < 8; o++) begin
         sw_osr_select = 3'(o);
         adc_a_data = 16'h8421 + 16'(o);
         adc_b_data = 16'h7bde - 16'(o);
         conv(o == 0 ? 22 : (1 << o) * 35, o == 1);
         readback(adc_a_data, adc_b_data);
      end
      sw_osr_select = 3'h0;
      for (int e = 0; e < 3; e++) begin
         seq_wr_idx = 3'(e);
         seq_wr_channel_a = 4'(e + 1);
         seq_wr_channel_b = 4'(7 - e);
         seq_wr_en = 1'b1;
         @(negedge core_clk);
         seq_wr_en = 1'b0;
         @(negedge core_clk);
      end
      seq_last = 3'h2;
      seq_enable = 1'b1;
      repeat (2) @(negedge core_clk);
      for (int i = 0; i < 4; i++) begin
         conv(22, 1'b0);
         chk(mux_a_select, (i % 3) + 1);
         chk(mux_b_select, 7 - (i % 3));
      end
      conclude();
   end
endmodule : testbench
